// [single_wire_if.sv]
// Purpose: shared data line between host and receiver
// Assumes: pull-up keeps the line high when nobody drives
// Notes  : enables are active low
`timescale 1ns/10ps
interface single_wire_if;
   logic hostTx;
   logic hostOeN;
   logic devTx;
   logic devOeN;
   logic line;

   // wired-and with pull-up: an undriven line reads high
   assign line = (hostOeN | hostTx) & (devOeN | devTx);

   modport host (output hostTx, output hostOeN, input line);
   modport dev  (output devTx, output devOeN, input line);
endinterface : single_wire_if

// [single_wire_uart_write_receiver_tb.sv]
// Purpose: self-checking bench for host and receivers
// Assumes: bench drives the second receiver at faster rates
// Notes  : host path runs beside receiver tests to save time
`timescale 1ns/10ps
module single_wire_uart_write_receiver_tb;
   import swu_pkg::*;
   typedef struct packed {
      logic [1:0]        node;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [7:0]        sync;
      logic [7:0]        bc;
      logic              take;
   } row_s;
   logic              clk = 1'b0;
   logic              rst;
   logic              ce;
   logic              reqValid;
   logic              reqReady;
   logic              reqWrite;
   logic              busy;
   logic [1:0]        reqNode;
   logic [ADDR_W-1:0] reqAddr;
   logic [DATA_W-1:0] reqData;
   logic              wrValid [2];
   logic              wrReady [2];
   logic [ADDR_W-1:0] wrAddr [2];
   logic [DATA_W-1:0] wrData [2];
   logic [CNT_W-1:0]  cnt [2];
   logic [1:0]        nodeSel [2];
   logic [CNT_W-1:0]  c0;
   logic [7:0]        hb [8];
   logic [9:0]        sb;
   row_s              fr;
   int                hn, w;
   int                errors = 0;
   int                checks_done = 0;
   row_s              rows [5] = '{
      '{2'h2, 1'b1, 7'h10, 32'h1234_5678, 8'h05, 8'h20, 1'b1},
      '{2'h1, 1'b1, 7'h22, 32'h89AB_CDEF, 8'h05, 8'h20, 1'b0},
      '{2'h2, 1'b0, 7'h11, 32'h0000_0000, 8'h05, 8'h20, 1'b0},
      '{2'h2, 1'b1, 7'h7F, 32'hA5C3_0F81, 8'h05, 8'h30, 1'b1},
      '{2'h2, 1'b1, 7'h00, 32'h0000_00FF, 8'hF5, 8'h20, 1'b1}
   };
   single_wire_if swi1 ();
   single_wire_if swi2 ();
   swu_host i_swu_host (.clk(clk), .rst(rst), .ce(ce), .swi(swi1.host), .reqValid(reqValid),
      .reqReady(reqReady), .reqNode(reqNode), .reqWrite(reqWrite), .reqAddr(reqAddr),
      .reqData(reqData), .busy(busy));
   swu_receiver i_swu_receiver (.clk(clk), .rst(rst), .ce(ce), .swi(swi1.dev),
      .nodePinLow(nodeSel[0][0]), .nodePinHigh(nodeSel[0][1]), .wrValid(wrValid[0]),
      .wrReady(wrReady[0]), .wrAddr(wrAddr[0]), .wrData(wrData[0]), .acceptCount(cnt[0]));
   swu_receiver i_swu_receiver_2 (.clk(clk), .rst(rst), .ce(ce), .swi(swi2.dev),
      .nodePinLow(nodeSel[1][0]), .nodePinHigh(nodeSel[1][1]), .wrValid(wrValid[1]),
      .wrReady(wrReady[1]), .wrAddr(wrAddr[1]), .wrData(wrData[1]), .acceptCount(cnt[1]));
   swu_link_checker i_swu_link_checker (.clk(clk), .rst(rst), .hostTx(swi1.hostTx),
      .hostOeN(swi1.hostOeN), .devTx(swi1.devTx), .devOeN(swi1.devOeN), .line(swi1.line));
   always #2 clk = ~clk;
   task automatic check(input string n, input logic [39:0] e, input logic [39:0] g);
      checks_done++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : check
   task automatic close_out();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : close_out
   function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] d);
      for (int i = 0; i < 8; i++) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc_byte
   task automatic mk(input row_s r, output logic [7:0] b [8], output int n);
      logic [7:0] c;
      b[0] = r.sync;
      b[1] = {6'h00, r.node};
      b[2] = {r.wr, r.addr};
      b[3] = r.data[31:24];
      b[4] = r.data[23:16];
      b[5] = r.data[15:8];
      b[6] = r.data[7:0];
      n = r.wr ? 7 : 3;
      c = CRC_INIT;
      for (int i = 0; i < n; i++) begin
         c = crc_byte(c, b[i]);
      end
      b[n] = c;
   endtask : mk
   // cut sends only three bytes
   task automatic send_dg(input row_s r, input logic bad, input logic cut);
      logic [7:0] b [8];
      int         n;
      mk(r, b, n);
      b[n] = b[n] ^ {7'h00, bad};
      swi2.hostOeN = 1'b0;
      for (int i = 0; i <= (cut ? 2 : n); i++) begin
         for (int j = 0; j < 10; j++) begin
            swi2.hostTx = (j == 0) ? 1'b0 : (j == 9) ? 1'b1 : b[i][j-1];
            repeat (r.bc) @(negedge clk);
         end
      end
      swi2.hostOeN = 1'b1;
   endtask : send_dg
   task automatic pop(input int k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      check("wrValid", 1, wrValid[k]);
      check("wrAddr", a, wrAddr[k]);
      check("wrData", d, wrData[k]);
      wrReady[k] = 1'b1;
      @(negedge clk);
      wrReady[k] = 1'b0;
   endtask : pop
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reqValid = 1'b0;
      reqNode = rows[1].node;
      reqWrite = rows[1].wr;
      reqAddr = rows[1].addr;
      reqData = rows[1].data;
      wrReady = '{1'b0, 1'b0};
      nodeSel = '{2'h1, 2'h2};
      swi2.hostTx = 1'b1;
      swi2.hostOeN = 1'b1;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      foreach (rows[i]) begin
         c0 = cnt[1];
         send_dg(rows[i], 1'b0, 1'b0);
         repeat (4 * rows[i].bc) @(negedge clk);
         if (rows[i].take) pop(1, rows[i].addr, rows[i].data);
         check("acceptCount", c0 + rows[i].take, cnt[1]);
         check("no extra", 0, wrValid[1]);
      end
      check("reset count", 0, cnt[0]);
      check("host ready", 1, reqReady);
      fork
         begin
            reqValid = 1'b1;
            @(negedge clk);
            reqValid = 1'b0;
            mk(rows[1], hb, hn);
            for (w = 0; w < 400 && swi1.line !== 1'b0; w++) @(negedge clk);
            repeat (HOST_BIT_CYC / 2) @(negedge clk);
            for (int i = 0; i <= hn; i++) begin
               for (int j = 0; j < 10; j++) begin
                  sb[j] = swi1.line;
                  repeat (HOST_BIT_CYC) @(negedge clk);
               end
               check("wire byte", {1'b1, hb[i], 1'b0}, sb);
            end
            for (w = 0; w < 4000 && busy !== 1'b0; w++) @(negedge clk);
            check("host ready again", 1, reqReady);
            pop(0, rows[1].addr, rows[1].data);
            check("host count", 1, cnt[0]);
         end
         begin
            for (int k = 0; k < 3; k++) begin
               c0 = cnt[1];
               if (k == 1) begin
                  swi2.hostOeN = 1'b0;
                  swi2.hostTx = 1'b0;
                  repeat (8) @(negedge clk);
                  swi2.hostTx = 1'b1;
                  swi2.hostOeN = 1'b1;
               end else begin
                  send_dg(rows[0], k == 0, k == 2);
               end
               repeat ((k == 2 ? 70 : 4) * 32) @(negedge clk);
               if (k < 2) begin
                  send_dg(rows[0], 1'b0, 1'b0);
                  repeat (16 * 32) @(negedge clk);
                  check("refused in recovery", c0, cnt[1]);
               end
               send_dg(rows[0], 1'b0, 1'b0);
               repeat (4 * 32) @(negedge clk);
               pop(1, rows[0].addr, rows[0].data);
               check("count after recovery", c0 + 1, cnt[1]);
            end
            c0 = cnt[1];
            fr = rows[0];
            fr.bc = 8'h14;
            // the 17th waits in push until one drains
            for (int i = 0; i < 17; i++) begin
               fr.data = 32'(i);
               send_dg(fr, 1'b0, 1'b0);
               repeat (4 * 20) @(negedge clk);
            end
            check("count at full", c0 + 16, cnt[1]);
            for (int i = 0; i < 17; i++) begin
               repeat (5) @(negedge clk);
               pop(1, fr.addr, 32'(i));
            end
            check("count drained", c0 + 17, cnt[1]);
            check("fifo empty", 0, wrValid[1]);
         end
      join
      close_out();
   end
endmodule : single_wire_uart_write_receiver_tb

// [swu_host.sv]
// Purpose: host end that sends write and read-request datagrams on the wire
// Assumes: fixed bit rate inside the receiver's accepted range
// Notes  : releases the line between datagrams; no reply path
`timescale 1ns/10ps
module swu_host
   import swu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   single_wire_if.host            swi,
   input  wire logic              reqValid,
   output logic                   reqReady,
   input  wire logic [1:0]        reqNode,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqData,
   output logic                   busy
);
   typedef enum logic [1:0] {hIdle, hBit, hGap} txState_e;

   txState_e          stateFF, nxt_state;
   logic [15:0]       tmrFF, nxt_tmr;
   logic [3:0]        bitNFF, nxt_bitN;
   logic [4:0]        gapNFF, nxt_gapN;
   logic [2:0]        byteIdxFF, nxt_byteIdx;
   logic [9:0]        frameFF, nxt_frame;
   logic [7:0]        crcFF, nxt_crc, curByte;
   logic              txFF, nxt_tx, oeNFF, nxt_oeN;
   logic              writeFF, nxt_write;
   logic [1:0]        nodeFF, nxt_node;
   logic [ADDR_W-1:0] addrFF, nxt_addr;
   logic [DATA_W-1:0] dataFF, nxt_data;
   logic              bitEnd, lastByte;

   assign reqReady    = stateFF == hIdle;
   assign busy        = stateFF != hIdle;
   assign swi.hostTx  = txFF;
   assign swi.hostOeN = oeNFF;
   assign bitEnd      = tmrFF == 16'(HOST_BIT_CYC - 1);
   assign lastByte    = byteIdxFF == (writeFF ? WR_LAST : RD_LAST);

   always_comb begin
      case (byteIdxFF)
         3'h0: curByte = {4'h0, SYNC_NIBBLE};
         3'h1: curByte = {6'h00, nodeFF};
         3'h2: curByte = {writeFF, addrFF};
         3'h3: curByte = writeFF ? dataFF[31:24] : crcFF;
         3'h4: curByte = dataFF[23:16];
         3'h5: curByte = dataFF[15:8];
         3'h6: curByte = dataFF[7:0];
         default: curByte = crcFF;
      endcase
   end

   always_comb begin
      nxt_state   = stateFF;
      nxt_tmr     = bitEnd ? '0 : tmrFF + 1'b1;
      nxt_bitN    = bitNFF;
      nxt_gapN    = gapNFF;
      nxt_byteIdx = byteIdxFF;
      nxt_frame   = frameFF;
      nxt_crc     = crcFF;
      nxt_tx      = txFF;
      nxt_oeN     = oeNFF;
      nxt_write   = writeFF;
      nxt_node    = nodeFF;
      nxt_addr    = addrFF;
      nxt_data    = dataFF;
      case (stateFF)
         hIdle: begin
            nxt_tmr = '0;
            nxt_tx  = 1'b1;
            nxt_oeN = 1'b1;
            if (reqValid) begin
               nxt_write   = reqWrite;
               nxt_node    = reqNode;
               nxt_addr    = reqAddr;
               nxt_data    = reqData;
               nxt_byteIdx = '0;
               nxt_crc     = CRC_INIT;
               nxt_frame   = {1'b1, 4'h0, SYNC_NIBBLE, 1'b0};
               nxt_bitN    = '0;
               nxt_tx      = 1'b1;
               nxt_oeN     = 1'b0;
               nxt_state   = hBit;
            end
         end
         hBit: begin
            if (tmrFF == '0) begin
               nxt_tx = frameFF[bitNFF];
            end
            if (bitEnd) begin
               nxt_bitN = bitNFF + 1'b1;
               if (bitNFF == 4'h9) begin
                  nxt_bitN = '0;
                  nxt_crc  = crc8(crcFF, curByte);
                  if (lastByte) begin
                     nxt_gapN  = '0;
                     nxt_state = hGap;
                  end else begin
                     nxt_byteIdx = byteIdxFF + 1'b1;
                  end
               end
            end
            if (bitNFF == 4'h0 && tmrFF == '0) begin
               nxt_frame = {1'b1, curByte, 1'b0};
            end
         end
         hGap: begin
            nxt_tx = 1'b1;
            if (bitEnd) begin
               nxt_gapN = gapNFF + 1'b1;
               if (gapNFF == 5'(RECOVER_BITS - 1)) begin
                  nxt_state = hIdle;
               end
            end
         end
         default: nxt_state = hIdle;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stateFF   <= hIdle;
         tmrFF     <= '0;
         bitNFF    <= '0;
         gapNFF    <= '0;
         byteIdxFF <= '0;
         frameFF   <= '1;
         crcFF     <= CRC_INIT;
         txFF      <= 1'b1;
         oeNFF     <= 1'b1;
         writeFF   <= 1'b0;
         nodeFF    <= '0;
         addrFF    <= '0;
         dataFF    <= '0;
      end else if (ce) begin
         stateFF   <= nxt_state;
         tmrFF     <= nxt_tmr;
         bitNFF    <= nxt_bitN;
         gapNFF    <= nxt_gapN;
         byteIdxFF <= nxt_byteIdx;
         frameFF   <= nxt_frame;
         crcFF     <= nxt_crc;
         txFF      <= nxt_tx;
         oeNFF     <= nxt_oeN;
         writeFF   <= nxt_write;
         nodeFF    <= nxt_node;
         addrFF    <= nxt_addr;
         dataFF    <= nxt_data;
      end
   end
endmodule : swu_host

// [swu_link_checker.sv]
// Purpose: wire-level checks on the host-to-receiver single-wire link
// Assumes: host sends HOST_BIT_CYC cycles per bit, one request at a time
// Notes  : bit centres are counted from the first cycle of a low enable
`timescale 1ns/10ps
module swu_link_checker
   import swu_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic hostTx,
   input wire logic hostOeN,
   input wire logic devTx,
   input wire logic devOeN,
   input wire logic line
);
   localparam int BC = HOST_BIT_CYC;
   logic [23:0] frameCnt_ff, nxt_frameCnt;
   logic        isWr_ff, nxt_isWr;
   int          bitNum, ph;
   logic        mid;
   always_comb begin
      bitNum = (int'(frameCnt_ff) - 1) / BC;
      ph = (int'(frameCnt_ff) - 1) % BC;
      mid = (frameCnt_ff != '0) && (ph == BC / 2);
      nxt_frameCnt = hostOeN ? '0 : frameCnt_ff + 1'b1;
      // access bit sets the frame length
      nxt_isWr = (mid && bitNum == 28) ? hostTx : isWr_ff;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         frameCnt_ff <= '0;
         isWr_ff <= 1'b0;
      end else begin
         frameCnt_ff <= nxt_frameCnt;
         isWr_ff <= nxt_isWr;
      end
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   property p_idle_high;
      hostOeN && devOeN |-> line;
   endproperty
   a_idle_high: assert property (p_idle_high) else $error("line low while released");
   property p_dev_quiet;
      devOeN && devTx;
   endproperty
   a_dev_quiet: assert property (p_dev_quiet) else $error("receiver drove the line");
   property p_lead_in;
      $fell(hostOeN) |-> hostTx ##1 !hostTx;
   endproperty
   a_lead_in: assert property (p_lead_in) else $error("frame did not open with start");
   property p_start_low;
      mid && bitNum < (isWr_ff ? 80 : 40) && bitNum % 10 == 0 |-> !hostTx;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low");
   property p_stop_high;
      mid && bitNum < 80 && bitNum % 10 == 9 |-> hostTx;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
   property p_sync_nib;
      mid && bitNum >= 1 && bitNum <= 4 |-> hostTx == SYNC_NIBBLE[bitNum-1];
   endproperty
   a_sync_nib: assert property (p_sync_nib) else $error("sync nibble wrong");
   property p_node_range;
      mid && bitNum >= 13 && bitNum <= 18 |-> !hostTx;
   endproperty
   a_node_range: assert property (p_node_range) else $error("node above 3");
   property p_bit_grid;
      !hostOeN && frameCnt_ff != '0 && $changed(hostTx) |-> ph == 0;
   endproperty
   a_bit_grid: assert property (p_bit_grid) else $error("bit edge off grid");
   property p_gap;
      $rose(hostOeN) |-> frameCnt_ff >= 24'((isWr_ff ? 92 : 52) * BC);
   endproperty
   a_gap: assert property (p_gap) else $error("released before idle gap");
endmodule : swu_link_checker

// [swu_pkg.sv]
// Purpose: constants and checksum for the single-wire write link
// Assumes: one 250 MHz clock on both ends
// Notes  : Overview of operation below
// Overview of operation
// - transfers open with sync nibble, node 0..3
// - receiver re-measures bit time every transfer
// - bytes framed by low start, high stop
// - bit time from start fall to sync fall
// - bytewise fields, data high byte first
// - host rate 9000 baud up to clock/16
// - node number from low and high pins
// - address byte top bit: 1 write, 0 read
// - over 63 bit times between starts resets
// - timeout uses last good datagram bit time
// - host idles 12 bit times after reset
// - low pulse under 16 cycles is glitch
// - checksum or framing error recovers like glitch
// - host never drops rate below 15 percent
// - accepted writes bump 8-bit wrapping counter
// - reads leave accepted-write counter alone
// - line rests high when no transfer runs
// - crc8 poly 0x07, zero init, lsb first
// - act only on good datagrams for own node
// - upper sync-byte bits ignored but checksummed
package swu_pkg;
   localparam int          CLK_HZ       = 250_000_000;
   localparam int          MIN_BAUD     = 9000;
   localparam int          BIT_MAX_CYC  = CLK_HZ / MIN_BAUD;
   localparam int          HOST_BAUD    = 1_000_000;
   localparam int          HOST_BIT_CYC = CLK_HZ / HOST_BAUD;
   localparam int          GLITCH_CYC   = 16;
   localparam int          TIMEOUT_BITS = 63;
   localparam int          RECOVER_BITS = 12;
   localparam int          SYNC_MAX_CYC = 5 * BIT_MAX_CYC;
   localparam int          MEAS_SHIFT   = 2;
   localparam int          TW           = 24;
   localparam int          ADDR_W       = 7;
   localparam int          DATA_W       = 32;
   localparam int          CNT_W        = 8;
   localparam int          FIFO_DEPTH   = 16;
   localparam int          RW_BIT       = 7;
   localparam logic [2:0]  WR_LAST      = 3'h7;
   localparam logic [2:0]  RD_LAST      = 3'h3;
   localparam logic [3:0]  SYNC_NIBBLE  = 4'h5;
   localparam logic [7:0]  SYNC_PRESET  = 8'h05;
   localparam logic [2:0]  SYNC_BITS    = 3'h3;
   localparam logic [7:0]  CRC_POLY     = 8'h07;
   localparam logic [7:0]  CRC_INIT     = 8'h00;

   function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
      logic [7:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         if (r[7] ^ b[i]) begin
            r = {r[6:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[6:0], 1'b0};
         end
      end
      return r;
   endfunction : crc8
endpackage : swu_pkg

// [swu_receiver.sv]
// Purpose: single-wire write datagram receiver with auto baud and write FIFO
// Assumes: host keeps to its rate and idle limits
// Notes  : never drives the line; read requests are checked and dropped
`timescale 1ns/10ps

module swu_fifo
   import swu_pkg::*;
#(
   parameter int W = 8,
   parameter int D = 16
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   input  wire logic         inValid,
   output logic              inReady,
   input  wire logic [W-1:0] inData,
   output logic              outValid,
   input  wire logic         outReady,
   output logic [W-1:0]      outData
);
   localparam int AW = $clog2(D);
   logic [W-1:0] mem [D];
   logic [AW:0]  wrPtrFF, rdPtrFF, nxt_wrPtr, nxt_rdPtr;
   logic         doWr, doRd;

   assign inReady  = (wrPtrFF ^ rdPtrFF) != {1'b1, {AW{1'b0}}};
   assign outValid = wrPtrFF != rdPtrFF;
   assign outData  = mem[rdPtrFF[AW-1:0]];
   assign doWr     = inValid && inReady;
   assign doRd     = outValid && outReady;

   always_comb begin
      nxt_wrPtr = doWr ? wrPtrFF + 1'b1 : wrPtrFF;
      nxt_rdPtr = doRd ? rdPtrFF + 1'b1 : rdPtrFF;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPtrFF <= '0;
         rdPtrFF <= '0;
      end else if (ce) begin
         wrPtrFF <= nxt_wrPtr;
         rdPtrFF <= nxt_rdPtr;
      end
   end

   always_ff @(posedge clk) begin
      if (ce && doWr) begin
         mem[wrPtrFF[AW-1:0]] <= inData;
      end
   end
endmodule : swu_fifo

module swu_receiver
   import swu_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              ce,
   single_wire_if.dev             swi,
   input  wire logic              nodePinLow,
   input  wire logic              nodePinHigh,
   output logic                   wrValid,
   input  wire logic              wrReady,
   output logic [ADDR_W-1:0]      wrAddr,
   output logic [DATA_W-1:0]      wrData,
   output logic [CNT_W-1:0]       acceptCount
);
   typedef enum logic [2:0] {
      stIdle, stSync, stWait, stStart, stData, stStop, stPush, stRecover
   } rxState_e;

   rxState_e            stateFF, nxt_state;
   logic [2:0]          rxSyncFF, lowSyncFF, highSyncFF;
   logic [TW-1:0]       cntFF, nxt_cnt, gapFF, nxt_gap;
   logic [TW-1:0]       bitTimeFF, nxt_bitTime, bitRefFF, nxt_bitRef;
   logic                refOkFF, nxt_refOk;
   logic                edgeSeenFF, nxt_edgeSeen;
   logic [7:0]          shiftFF, nxt_shift, crcFF, nxt_crc;
   logic [2:0]          bitIdxFF, nxt_bitIdx, byteIdxFF, nxt_byteIdx;
   logic                writeFF, nxt_write, nodeOkFF, nxt_nodeOk;
   logic [ADDR_W-1:0]   regFF, nxt_reg;
   logic [DATA_W-1:0]   dataFF, nxt_data;
   logic [CNT_W-1:0]    countFF, nxt_count;
   logic                rxS, rise, fall, err, push, pushReady, lastByte;
   logic [1:0]          nodeSel;
   logic [TW-1:0]       bitUse, limit63, limit12, meas;

   // receiver only listens; its driver stays off
   assign swi.devTx  = 1'b1;
   assign swi.devOeN = 1'b1;

   assign rxS      = rxSyncFF[1];
   assign rise     = rxSyncFF[1] & ~rxSyncFF[2];
   assign fall     = ~rxSyncFF[1] & rxSyncFF[2];
   assign nodeSel  = {highSyncFF[1], lowSyncFF[1]};
   assign bitUse   = refOkFF ? bitRefFF : bitTimeFF;
   assign limit63  = TW'(bitUse * TIMEOUT_BITS);
   assign limit12  = TW'(bitUse * RECOVER_BITS);
   assign meas     = cntFF >> MEAS_SHIFT;
   assign lastByte = (byteIdxFF == WR_LAST) || (byteIdxFF == RD_LAST && !writeFF);
   assign acceptCount = countFF;

   always_comb begin
      nxt_state    = stateFF;
      nxt_cnt      = cntFF + 1'b1;
      nxt_gap      = (&gapFF) ? gapFF : gapFF + 1'b1;
      nxt_bitTime  = bitTimeFF;
      nxt_bitRef   = bitRefFF;
      nxt_refOk    = refOkFF;
      nxt_edgeSeen = edgeSeenFF;
      nxt_shift    = shiftFF;
      nxt_crc      = crcFF;
      nxt_bitIdx   = bitIdxFF;
      nxt_byteIdx  = byteIdxFF;
      nxt_write    = writeFF;
      nxt_nodeOk   = nodeOkFF;
      nxt_reg      = regFF;
      nxt_data     = dataFF;
      nxt_count    = countFF;
      err          = 1'b0;
      push         = 1'b0;
      case (stateFF)
         stIdle: begin
            nxt_cnt     = '0;
            nxt_crc     = CRC_INIT;
            nxt_byteIdx = '0;
            if (fall) begin
               nxt_state    = stSync;
               nxt_cnt      = TW'(1);
               nxt_gap      = '0;
               nxt_edgeSeen = 1'b0;
            end
         end
         stSync: begin
            if (rise && cntFF < TW'(GLITCH_CYC)) begin
               err = 1'b1;
            end else if (fall) begin
               if (edgeSeenFF) begin
                  nxt_bitTime = meas;
                  nxt_cnt     = meas >> 1;
                  nxt_shift   = SYNC_PRESET;
                  nxt_bitIdx  = SYNC_BITS;
                  nxt_state   = stData;
               end else begin
                  nxt_edgeSeen = 1'b1;
               end
            end else if (cntFF >= TW'(SYNC_MAX_CYC)) begin
               err = 1'b1;
            end
         end
         stWait: begin
            if (fall) begin
               nxt_gap   = '0;
               nxt_cnt   = bitTimeFF >> 1;
               nxt_state = stStart;
            end else if (gapFF > limit63) begin
               err = 1'b1;
            end
         end
         stStart: begin
            if (rise && gapFF < TW'(GLITCH_CYC)) begin
               err = 1'b1;
            end else if (cntFF >= bitTimeFF) begin
               if (rxS) begin
                  err = 1'b1;
               end else begin
                  nxt_cnt    = TW'(1);
                  nxt_bitIdx = '0;
                  nxt_state  = stData;
               end
            end
         end
         stData: begin
            if (cntFF >= bitTimeFF) begin
               nxt_shift[bitIdxFF] = rxS;
               nxt_cnt             = TW'(1);
               nxt_bitIdx          = bitIdxFF + 1'b1;
               if (bitIdxFF == 3'h7) begin
                  nxt_state = stStop;
               end
            end
         end
         stStop: begin
            if (cntFF >= bitTimeFF) begin
               if (!rxS) begin
                  err = 1'b1;
               end else if (lastByte) begin
                  nxt_byteIdx = '0;
                  if (shiftFF == crcFF) begin
                     nxt_bitRef = bitTimeFF;
                     nxt_refOk  = 1'b1;
                     nxt_state  = (writeFF && nodeOkFF) ? stPush : stIdle;
                  end else begin
                     err = 1'b1;
                  end
               end else begin
                  nxt_crc     = crc8(crcFF, shiftFF);
                  nxt_byteIdx = byteIdxFF + 1'b1;
                  nxt_state   = stWait;
                  case (byteIdxFF)
                     3'h0: err = shiftFF[3:0] != SYNC_NIBBLE;
                     3'h1: nxt_nodeOk = shiftFF == {6'h00, nodeSel};
                     3'h2: begin
                        nxt_write = shiftFF[RW_BIT];
                        nxt_reg   = shiftFF[ADDR_W-1:0];
                     end
                     default: nxt_data = {dataFF[DATA_W-9:0], shiftFF};
                  endcase
               end
            end
         end
         stPush: begin
            // a full queue stalls here and later datagrams are lost
            push = 1'b1;
            if (pushReady) begin
               nxt_count = countFF + 1'b1;
               nxt_state = stIdle;
            end
         end
         stRecover: begin
            if (!rxS) begin
               nxt_cnt = '0;
            end else if (cntFF >= limit12) begin
               nxt_state = stIdle;
            end
         end
         default: nxt_state = stIdle;
      endcase
      if (err) begin
         nxt_state   = stRecover;
         nxt_cnt     = '0;
         nxt_byteIdx = '0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rxSyncFF   <= 3'h7;
         lowSyncFF  <= '0;
         highSyncFF <= '0;
         stateFF    <= stIdle;
         cntFF      <= '0;
         gapFF      <= '0;
         bitTimeFF  <= TW'(BIT_MAX_CYC);
         bitRefFF   <= TW'(BIT_MAX_CYC);
         refOkFF    <= 1'b0;
         edgeSeenFF <= 1'b0;
         shiftFF    <= '0;
         crcFF      <= CRC_INIT;
         bitIdxFF   <= '0;
         byteIdxFF  <= '0;
         writeFF    <= 1'b0;
         nodeOkFF   <= 1'b0;
         regFF      <= '0;
         dataFF     <= '0;
         countFF    <= '0;
      end else if (ce) begin
         rxSyncFF   <= {rxSyncFF[1:0], swi.line};
         lowSyncFF  <= {lowSyncFF[1:0], nodePinLow};
         highSyncFF <= {highSyncFF[1:0], nodePinHigh};
         stateFF    <= nxt_state;
         cntFF      <= nxt_cnt;
         gapFF      <= nxt_gap;
         bitTimeFF  <= nxt_bitTime;
         bitRefFF   <= nxt_bitRef;
         refOkFF    <= nxt_refOk;
         edgeSeenFF <= nxt_edgeSeen;
         shiftFF    <= nxt_shift;
         crcFF      <= nxt_crc;
         bitIdxFF   <= nxt_bitIdx;
         byteIdxFF  <= nxt_byteIdx;
         writeFF    <= nxt_write;
         nodeOkFF   <= nxt_nodeOk;
         regFF      <= nxt_reg;
         dataFF     <= nxt_data;
         countFF    <= nxt_count;
      end
   end

   swu_fifo #(.W(ADDR_W + DATA_W), .D(FIFO_DEPTH)) u_fifo (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .inValid  (push),
      .inReady  (pushReady),
      .inData   ({regFF, dataFF}),
      .outValid (wrValid),
      .outReady (wrReady),
      .outData  ({wrAddr, wrData})
   );
endmodule : swu_receiver
